// ---- core/flash_host_pkg.sv ----
// constants, register map and types shared by the flash host controller
// assumes a 100 MHz system clock and a x16 parallel flash on the far side
package flash_host_pkg;

    localparam int CLK_PERIOD_NS   = 10;
    localparam int T_SETUP_NS      = 20;
    localparam int T_WR_PULSE_NS   = 50;
    localparam int T_RD_ACCESS_NS  = 120;
    localparam int T_HOLD_NS       = 10;
    localparam int T_RST_PULSE_NS  = 500;
    localparam int T_POR_US        = 300;
    localparam int SYNC_STAGES     = 2;

    localparam logic [15:0] SETUP_CYC = 16'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] WR_CYC    = 16'((T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] RD_CYC    =
        16'((T_RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
    localparam logic [15:0] HOLD_CYC  = 16'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] RST_CYC   = 16'((T_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          POR_CYC_DEFAULT = (T_POR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register offsets on the software port
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_ADDR    = 8'h04;
    localparam logic [7:0] REG_WDATA   = 8'h08;
    localparam logic [7:0] REG_OVL     = 8'h0c;
    localparam logic [7:0] REG_STATUS  = 8'h10;
    localparam logic [7:0] REG_RAW     = 8'h14;
    localparam logic [7:0] REG_DECODED = 8'h18;

    // status field positions
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_ERR     = 2;
    localparam int ST_READY   = 3;
    localparam int ST_LOCKOUT = 4;
    localparam int ST_OVL_LSB = 8;

    // flash address and data layout
    localparam int SECTOR_LSB        = 16;
    localparam int CMD_PATTERN_MSB   = 10;
    localparam int ECC_PAGE_WORDS    = 16;
    localparam int ECC_PAGE_LSB      = 4;
    localparam int ECC_CODE_FIX_BIT  = 2;
    localparam int ECC_DATA_FIX_BIT  = 1;
    localparam int OVL_BIT           = 0;
    localparam int PASSWORD_WORDS    = 4;
    localparam int OTP_TOTAL_BYTES   = 1024;
    localparam int OTP_HALF_BYTES    = 512;
    localparam int OTP_WORDS         = OTP_TOTAL_BYTES / 2;

    typedef enum logic [2:0] {
        OVL_NONE, OVL_LOCK, OVL_PASSWORD, OVL_DYB, OVL_PPB, OVL_ECC, OVL_SECURE
    } overlay_t;

    typedef enum logic [2:0] {
        OP_NOP, OP_WRITE, OP_READ, OP_ENTER, OP_EXIT, OP_HWRESET
    } op_t;

    typedef enum logic [1:0] {
        CYC_WRITE, CYC_READ, CYC_RESET
    } cyc_t;

endpackage : flash_host_pkg

// ---- core/flash_bus_cycle.sv ----
// one flash pin cycle: write strobe, read strobe or hardware reset pulse
// assumes the caller holds i_start for one cycle only while idle
`timescale 1ns/1ns
`default_nettype none
module flash_bus_cycle
    import flash_host_pkg::*;
#(
    parameter int ADDR_W = 26,
    parameter int DATA_W = 16
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire logic              i_start,
    input  wire cyc_t              i_kind,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [DATA_W-1:0] i_dq,
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rdata,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [DATA_W-1:0]      o_dq,
    output logic                   o_dq_oe,
    output logic                   o_ce_n,
    output logic                   o_we_n,
    output logic                   o_oe_n,
    output logic                   o_reset_n
);

    typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD} cyc_state_t;

    cyc_state_t        state_q;
    cyc_t              kind_q;
    logic [15:0]       cnt_q;
    logic [DATA_W-1:0] dq_s1_q;
    logic [DATA_W-1:0] dq_s2_q;
    wire  logic [15:0] strobe_len;
    wire  logic        cnt_last;

    assign strobe_len = (kind_q == CYC_READ)  ? RD_CYC :
                        (kind_q == CYC_RESET) ? RST_CYC : WR_CYC;
    assign cnt_last   = (cnt_q == 16'h0001);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q   <= S_IDLE;
            kind_q    <= CYC_WRITE;
            cnt_q     <= 16'h0000;
            dq_s1_q   <= '0;
            dq_s2_q   <= '0;
            o_done    <= 1'b0;
            o_rdata   <= '0;
            o_addr    <= '0;
            o_dq      <= '0;
            o_dq_oe   <= 1'b0;
            o_ce_n    <= 1'b1;
            o_we_n    <= 1'b1;
            o_oe_n    <= 1'b1;
            o_reset_n <= 1'b1;
        end else if (i_ce) begin
            dq_s1_q <= i_dq;
            dq_s2_q <= dq_s1_q;
            o_done  <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (i_start) begin
                        kind_q  <= i_kind;
                        o_addr  <= i_addr;
                        o_dq    <= i_wdata;
                        o_dq_oe <= (i_kind == CYC_WRITE);
                        o_ce_n  <= (i_kind == CYC_RESET);
                        cnt_q   <= SETUP_CYC;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_last) begin
                        o_we_n    <= (kind_q != CYC_WRITE);
                        o_oe_n    <= (kind_q != CYC_READ);
                        o_reset_n <= (kind_q != CYC_RESET);
                        cnt_q     <= strobe_len;
                        state_q   <= S_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                S_STROBE: begin
                    if (cnt_last) begin
                        if (kind_q == CYC_READ) begin
                            o_rdata <= dq_s2_q;
                        end
                        o_we_n    <= 1'b1;
                        o_oe_n    <= 1'b1;
                        o_reset_n <= 1'b1;
                        cnt_q     <= HOLD_CYC;
                        state_q   <= S_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                S_HOLD: begin
                    if (cnt_last) begin
                        o_ce_n  <= 1'b1;
                        o_dq_oe <= 1'b0;
                        o_done  <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    property p_we_pulse;
        @(posedge i_clk) disable iff (i_rst || !i_ce)
        $fell(o_we_n) |-> (!o_we_n)[*5] ##1 o_we_n;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");

    property p_no_contention;
        @(posedge i_clk) disable iff (i_rst)
        !o_oe_n |-> !o_dq_oe && o_we_n;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("dq driven during read");

endmodule : flash_bus_cycle
`default_nettype wire

// ---- core/flash_host_ctrl.sv ----
// host controller for a parallel NOR flash: overlay reads, command writes, reset
// assumes software on a simple strobe port; flash pins and lockout pin are asynchronous
//
// Contract
// - host reads or programs the lock bit only at address zero; only reads are forced to zero, writes use REG_ADDR as set
// - host touches dynamic bits only at the sector's address zero; only reads are forced there, writes use REG_ADDR as set
// - ECC overlay entered from read mode; only status read and exit allowed
// - host holds chip select or output enable high through power-on
// - bad sequences give standby; else host sends reset command or pulse
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int ADDR_W      = 26,
    parameter int DATA_W      = 16,
    parameter int POR_CYCLES  = POR_CYC_DEFAULT
) (
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RST,
    input  wire logic              I_CE,
    input  wire logic [7:0]        I_ADDR,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic              I_WE,
    input  wire logic              I_RE,
    output logic      [31:0]       O_RDATA,
    input  wire logic [DATA_W-1:0] I_FLASH_DQ,
    input  wire logic              I_SUPPLY_LOW,
    output logic      [ADDR_W-1:0] O_FLASH_ADDR,
    output logic      [DATA_W-1:0] O_FLASH_DQ,
    output logic                   O_FLASH_DQ_OE,
    output logic                   O_FLASH_CE_N,
    output logic                   O_FLASH_WE_N,
    output logic                   O_FLASH_OE_N,
    output logic                   O_FLASH_RESET_N
);

    localparam int POR_W = $clog2(POR_CYCLES + 1);

    typedef enum {T_POR, T_IDLE, T_WAIT} top_state_t;

    top_state_t        state_q;
    logic [POR_W-1:0]  por_cnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    overlay_t          tgt_ovl_q;
    overlay_t          act_ovl_q;
    overlay_t          raw_ovl_q;
    op_t               op_q;
    logic [DATA_W-1:0] raw_q;
    logic              done_q;
    logic              err_q;
    logic              lock_s1_q;
    logic              lock_s2_q;
    logic              eng_start_q;
    cyc_t              eng_kind_q;
    logic [ADDR_W-1:0] eng_addr_q;
    logic              eng_done;
    logic [DATA_W-1:0] eng_rdata;

    // read address as the overlay in force wants it
    function automatic logic [ADDR_W-1:0] rd_addr_f(input overlay_t ovl,
                                                    input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] r;
        r = a;
        case (ovl)
            OVL_LOCK:         r = '0;
            OVL_DYB, OVL_PPB: r[SECTOR_LSB-1:0] = '0;
            OVL_ECC:          r[ECC_PAGE_LSB-1:0] = '0;
            default:          r = a;
        endcase
        return r;
    endfunction : rd_addr_f

    wire logic        wr_ctrl    = I_WE && (I_ADDR == REG_CTRL);
    wire logic        wr_status  = I_WE && (I_ADDR == REG_STATUS);
    wire op_t         op_w       = op_t'(I_WDATA[2:0]);
    wire logic        op_valid   = (op_w != OP_NOP) && (I_WDATA[2:0] <= 3'(OP_HWRESET));
    wire logic        op_is_wr   = (op_w == OP_WRITE) || (op_w == OP_ENTER) ||
                                   (op_w == OP_EXIT);
    wire logic [SECTOR_LSB-1:0] sec_off = addr_q[SECTOR_LSB-1:0];
    wire logic        pw_bad     = (act_ovl_q == OVL_PASSWORD) &&
                                   (addr_q >= ADDR_W'(PASSWORD_WORDS));
    wire logic        otp_bad    = (act_ovl_q == OVL_SECURE) &&
                                   (sec_off >= SECTOR_LSB'(OTP_WORDS));
    wire logic        ecc_bad    = (act_ovl_q == OVL_ECC) &&
                                   (op_w != OP_READ) && (op_w != OP_EXIT);
    wire logic        enter_bad  = (op_w == OP_ENTER) && (tgt_ovl_q == OVL_ECC) &&
                                   (act_ovl_q != OVL_NONE);
    wire logic        refuse     = !op_valid || (state_q != T_IDLE) ||
                                   (op_is_wr && lock_s2_q) ||
                                   ((op_w == OP_READ) && (pw_bad || otp_bad)) ||
                                   ecc_bad || enter_bad;
    wire logic        launch     = wr_ctrl && !refuse;
    wire cyc_t        kind_w     = (op_w == OP_READ)    ? CYC_READ :
                                   (op_w == OP_HWRESET) ? CYC_RESET : CYC_WRITE;
    wire logic [ADDR_W-1:0] start_addr = (op_w == OP_READ) ?
                                   rd_addr_f(act_ovl_q, addr_q) : addr_q;
    wire logic        fin        = (state_q == T_WAIT) && eng_done;
    wire logic        bit_ovl    = (raw_ovl_q == OVL_LOCK) || (raw_ovl_q == OVL_DYB) ||
                                   (raw_ovl_q == OVL_PPB);

    wire logic [31:0] status_w;
    wire logic [31:0] decoded_w;
    wire logic [31:0] rd_mux;

    assign status_w = (32'(act_ovl_q) << ST_OVL_LSB) |
                      (32'(lock_s2_q) << ST_LOCKOUT) |
                      (32'(state_q != T_POR) << ST_READY) |
                      (32'(err_q) << ST_ERR) |
                      (32'(done_q) << ST_DONE) |
                      (32'(state_q == T_WAIT) << ST_BUSY);

    // only the bits the overlay defines are passed; the rest reads as zero
    assign decoded_w = bit_ovl ? (32'(raw_q[OVL_BIT]) << OVL_BIT) :
                       (raw_ovl_q == OVL_ECC) ?
                       ((32'(raw_q[ECC_CODE_FIX_BIT]) << ECC_CODE_FIX_BIT) |
                        (32'(raw_q[ECC_DATA_FIX_BIT]) << ECC_DATA_FIX_BIT)) :
                       32'h0000_0000;

    assign rd_mux = (I_ADDR == REG_ADDR)    ? 32'(addr_q)    :
                    (I_ADDR == REG_WDATA)   ? 32'(wdata_q)   :
                    (I_ADDR == REG_OVL)     ? 32'(tgt_ovl_q) :
                    (I_ADDR == REG_STATUS)  ? status_w       :
                    (I_ADDR == REG_RAW)     ? 32'(raw_q)     :
                    (I_ADDR == REG_DECODED) ? decoded_w      : 32'h0000_0000;

    // lockout pin crosses into the clock domain
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else if (I_CE) begin
            lock_s1_q <= I_SUPPLY_LOW;
            lock_s2_q <= lock_s1_q;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_RDATA <= 32'h0000_0000;
            addr_q    <= '0;
            wdata_q   <= '0;
            tgt_ovl_q <= OVL_NONE;
        end else if (I_CE) begin
            O_RDATA <= I_RE ? rd_mux : 32'h0000_0000;
            if (I_WE && (I_ADDR == REG_ADDR)) begin
                addr_q <= I_WDATA[ADDR_W-1:0];
            end
            if (I_WE && (I_ADDR == REG_WDATA)) begin
                wdata_q <= I_WDATA[DATA_W-1:0];
            end
            if (I_WE && (I_ADDR == REG_OVL)) begin
                tgt_ovl_q <= overlay_t'(I_WDATA[2:0]);
            end
        end
    end

    // sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            done_q <= 1'b0;
            err_q  <= 1'b0;
        end else if (I_CE) begin
            done_q <= fin || (done_q && !(wr_status && I_WDATA[ST_DONE]));
            err_q  <= (wr_ctrl && refuse) || (err_q && !(wr_status && I_WDATA[ST_ERR]));
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            state_q     <= T_POR;
            por_cnt_q   <= '0;
            op_q        <= OP_NOP;
            act_ovl_q   <= OVL_NONE;
            raw_ovl_q   <= OVL_NONE;
            raw_q       <= '0;
            eng_start_q <= 1'b0;
            eng_kind_q  <= CYC_WRITE;
            eng_addr_q  <= '0;
        end else if (I_CE) begin
            eng_start_q <= 1'b0;
            case (state_q)
                T_POR: begin
                    // pins stay idle and high until the device has finished power-on
                    if (por_cnt_q == POR_W'(POR_CYCLES)) begin
                        state_q <= T_IDLE;
                    end else begin
                        por_cnt_q <= por_cnt_q + 1'b1;
                    end
                end
                T_IDLE: begin
                    if (launch) begin
                        op_q        <= op_w;
                        eng_start_q <= 1'b1;
                        eng_kind_q  <= kind_w;
                        eng_addr_q  <= start_addr;
                        state_q     <= T_WAIT;
                    end
                end
                T_WAIT: begin
                    if (eng_done) begin
                        state_q <= T_IDLE;
                        case (op_q)
                            OP_ENTER: act_ovl_q <= tgt_ovl_q;
                            OP_EXIT, OP_HWRESET: act_ovl_q <= OVL_NONE;
                            OP_READ: begin
                                raw_q     <= eng_rdata;
                                raw_ovl_q <= act_ovl_q;
                            end
                            default: act_ovl_q <= act_ovl_q;
                        endcase
                    end
                end
                default: begin
                    state_q <= T_IDLE;
                end
            endcase
        end
    end

    flash_bus_cycle #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_cycle (
        .i_clk     (I_SYS_CLK),
        .i_rst     (I_RST),
        .i_ce      (I_CE),
        .i_start   (eng_start_q),
        .i_kind    (eng_kind_q),
        .i_addr    (eng_addr_q),
        .i_wdata   (wdata_q),
        .i_dq      (I_FLASH_DQ),
        .o_done    (eng_done),
        .o_rdata   (eng_rdata),
        .o_addr    (O_FLASH_ADDR),
        .o_dq      (O_FLASH_DQ),
        .o_dq_oe   (O_FLASH_DQ_OE),
        .o_ce_n    (O_FLASH_CE_N),
        .o_we_n    (O_FLASH_WE_N),
        .o_oe_n    (O_FLASH_OE_N),
        .o_reset_n (O_FLASH_RESET_N)
    );

    property p_por_quiet;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (state_q == T_POR) |-> O_FLASH_CE_N && O_FLASH_OE_N && O_FLASH_WE_N;
    endproperty
    a_por_quiet: assert property (p_por_quiet) else $error("pins active in power-on");

    property p_lockout_write;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (eng_start_q && eng_kind_q == CYC_WRITE) |-> !$past(lock_s2_q);
    endproperty
    a_lockout_write: assert property (p_lockout_write) else $error("write under lockout");

    property p_lock_addr;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (eng_start_q && eng_kind_q == CYC_READ && act_ovl_q == OVL_LOCK) |-> eng_addr_q == '0;
    endproperty
    a_lock_addr: assert property (p_lock_addr) else $error("lock read not at zero");

    property p_dyb_addr;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (eng_start_q && eng_kind_q == CYC_READ && (act_ovl_q == OVL_DYB ||
         act_ovl_q == OVL_PPB)) |-> eng_addr_q[SECTOR_LSB-1:0] == '0;
    endproperty
    a_dyb_addr: assert property (p_dyb_addr) else $error("bit read off sector base");

    property p_ecc_page;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (eng_start_q && act_ovl_q == OVL_ECC) |->
            eng_addr_q[ECC_PAGE_LSB-1:0] == '0 || eng_kind_q != CYC_READ;
    endproperty
    a_ecc_page: assert property (p_ecc_page) else $error("ECC read not page aligned");

    property p_ecc_ops;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (eng_start_q && act_ovl_q == OVL_ECC) |-> (op_q == OP_READ || op_q == OP_EXIT);
    endproperty
    a_ecc_ops: assert property (p_ecc_ops) else $error("illegal op in ECC overlay");

    property p_pw_range;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (eng_start_q && eng_kind_q == CYC_READ && act_ovl_q == OVL_PASSWORD) |->
            eng_addr_q < ADDR_W'(PASSWORD_WORDS);
    endproperty
    a_pw_range: assert property (p_pw_range) else $error("password read out of range");

    property p_exit;
        @(posedge I_SYS_CLK) disable iff (I_RST || !I_CE)
        (fin && op_q == OP_EXIT) |=> act_ovl_q == OVL_NONE ##1 act_ovl_q == OVL_NONE;
    endproperty
    a_exit: assert property (p_exit) else $error("overlay kept after exit");

    property p_rdata_slot;
        @(posedge I_SYS_CLK) disable iff (I_RST || !I_CE)
        !I_RE |=> O_RDATA == 32'h0000_0000;
    endproperty
    a_rdata_slot: assert property (p_rdata_slot) else $error("read data outside slot");

endmodule : flash_host_ctrl
`default_nettype wire

// ---- verif/flash_dev_model.sv ----
// behavioural x16 flash: overlays, dynamic protect bits, ECC page status
// assumes test codes: a5xx enters overlay xx, 00f0 exits, 60xx clears a sector's dynamic bit
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model (
    input  wire logic [25:0] i_addr,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_reset_n,
    input  wire logic        i_supply_low,
    output logic      [15:0] o_dq
);
    logic [2:0]    ovl = 3'h0;
    logic          lock = 1'h1;
    logic [1023:0] dynamic_sector_protect_bit = '1;
    logic [15:0]   rd;
    logic [15:0]   last = 16'h0;
    wire  [9:0]    sec = i_addr[25:16];
    wire           sel = !i_ce_n && !i_oe_n && i_reset_n;
    always @(posedge i_we_n or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ovl = 3'h0;
            lock = 1'h1;
            dynamic_sector_protect_bit = '1;
        end else if (!i_ce_n && !i_supply_low) begin
            if (i_dq[15:8] == 8'ha5)
                ovl = i_dq[2:0];
            else if (i_dq == 16'h00f0)
                ovl = 3'h0;
            else if (i_dq[15:8] == 8'h60 && ovl == 3'h0)
                dynamic_sector_protect_bit[sec] = 1'h0;
        end
    end
    always_comb begin
        case (ovl)
            3'h1:    rd = {15'h7fff, lock};
            3'h3:    rd = {15'h7fff, dynamic_sector_protect_bit[sec]};
            // persistent bits are left erased, so every sector reads unprotected
            3'h4:    rd = {15'h7fff, 1'h1};
            3'h5:    rd = {13'h1fff, i_addr[5:4], 1'h1};
            default: rd = i_addr[15:0] ^ 16'h5a5a;
        endcase
    end
    always @(*) begin
        if (sel)
            last = rd;
    end
    // released bus shows the inverse of the last word
    assign o_dq = sel ? rd : ~last;
endmodule : flash_dev_model
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the flash host controller against a behavioural flash
// assumes flash_dev_model answers the test command codes used below
`timescale 1ns/1ns
`default_nettype none
module testbench
    import flash_host_pkg::*;
;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        we = 1'h0;
    logic        re = 1'h0;
    logic        low = 1'h0;
    logic [7:0]  a = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic [25:0] f_addr;
    logic [15:0] f_dq;
    logic [15:0] dev_dq;
    logic        f_oe, ce_n, we_n, oe_n, rst_n;
    int          n_fail = 0;
    int          checked = 0;
    int          cyc = 0;
    wire  [15:0] dq_in = f_oe ? f_dq : dev_dq;
    flash_host_ctrl #(.POR_CYCLES(20)) uut (.I_SYS_CLK(clk), .I_RST(rst), .I_CE(1'h1),
        .I_ADDR(a), .I_WDATA(wd), .I_WE(we), .I_RE(re), .O_RDATA(rdata), .I_FLASH_DQ(dq_in),
        .I_SUPPLY_LOW(low), .O_FLASH_ADDR(f_addr), .O_FLASH_DQ(f_dq), .O_FLASH_DQ_OE(f_oe),
        .O_FLASH_CE_N(ce_n), .O_FLASH_WE_N(we_n), .O_FLASH_OE_N(oe_n), .O_FLASH_RESET_N(rst_n));
    flash_dev_model dev (.i_addr(f_addr), .i_dq(dq_in), .i_ce_n(ce_n), .i_we_n(we_n),
        .i_oe_n(oe_n), .i_reset_n(rst_n), .i_supply_low(low), .o_dq(dev_dq));
    initial forever #5 clk = ~clk;
    task automatic results();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            results();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        a <= ad;
        wd <= d;
        we <= 1'h1;
        @(posedge clk);
        we <= 1'h0;
    endtask : wr
    task automatic rc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] x);
        @(posedge clk);
        a <= ad;
        re <= 1'h1;
        @(posedge clk);
        re <= 1'h0;
        #1 chk(rdata & m, x);
    endtask : rc
    // run one op and wait for done or err; err compared with e
    task automatic go(input op_t c, input logic [2:0] ov, input logic [25:0] ad,
                      input logic [15:0] d, input logic e);
        int n = 0;
        wr(REG_OVL, {29'h0, ov});
        wr(REG_ADDR, {6'h0, ad});
        wr(REG_WDATA, {16'h0, d});
        wr(REG_CTRL, {29'h0, c});
        while (rdata[ST_DONE] !== 1'h1 && rdata[ST_ERR] !== 1'h1 && n < 100) begin
            @(posedge clk);
            a <= REG_STATUS;
            re <= 1'h1;
            @(posedge clk);
            re <= 1'h0;
            #1 n++;
        end
        chk({30'h0, rdata[ST_DONE], rdata[ST_ERR]}, {30'h0, !e, e});
        wr(REG_STATUS, 32'h6);
    endtask : go
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        rc(REG_STATUS, 32'h8, 32'h0);
        chk({29'h0, ce_n, we_n, oe_n}, 32'h7);
        go(OP_READ, 3'h0, 26'h0, 16'h0, 1'h1);
        repeat (40) @(posedge clk);
        rc(REG_STATUS, 32'h8, 32'h8);
        rc(8'h1c, 32'hffffffff, 32'h0);
        go(OP_READ, 3'h0, 26'h0123, 16'h0, 1'h0);
        rc(REG_RAW, 32'hffff, 32'h5b79);
        go(OP_ENTER, 3'h1, 26'h0, 16'ha501, 1'h0);
        go(OP_READ, 3'h1, 26'h30007, 16'h0, 1'h0);
        rc(REG_DECODED, 32'h1, 32'h1);
        go(OP_EXIT, 3'h1, 26'h0, 16'h00f0, 1'h0);
        go(OP_READ, 3'h0, 26'h0123, 16'h0, 1'h0);
        rc(REG_RAW, 32'hffff, 32'h5b79);
        go(OP_WRITE, 3'h0, 26'h50000, 16'h6000, 1'h0);
        go(OP_ENTER, 3'h3, 26'h50000, 16'ha503, 1'h0);
        go(OP_READ, 3'h3, 26'h5abcd, 16'h0, 1'h0);
        rc(REG_DECODED, 32'h1, 32'h0);
        go(OP_READ, 3'h3, 26'h60000, 16'h0, 1'h0);
        rc(REG_DECODED, 32'h1, 32'h1);
        go(OP_EXIT, 3'h3, 26'h0, 16'h00f0, 1'h0);
        go(OP_ENTER, 3'h4, 26'h0, 16'ha504, 1'h0);
        rc(REG_OVL, 32'h7, 32'h4);
        rc(REG_STATUS, 32'h700, 32'h400);
        go(OP_READ, 3'h4, 26'h70123, 16'h0, 1'h0);
        rc(REG_DECODED, 32'h1, 32'h1);
        go(OP_EXIT, 3'h4, 26'h0, 16'h00f0, 1'h0);
        go(OP_ENTER, 3'h5, 26'h0, 16'ha505, 1'h0);
        go(OP_READ, 3'h5, 26'h20, 16'h0, 1'h0);
        rc(REG_DECODED, 32'h6, 32'h4);
        go(OP_READ, 3'h5, 26'h1f, 16'h0, 1'h0);
        rc(REG_DECODED, 32'h6, 32'h2);
        go(OP_WRITE, 3'h5, 26'h0, 16'h6000, 1'h1);
        go(OP_EXIT, 3'h5, 26'h0, 16'h00f0, 1'h0);
        go(OP_ENTER, 3'h2, 26'h0, 16'ha502, 1'h0);
        go(OP_READ, 3'h2, 26'h3, 16'h0, 1'h0);
        rc(REG_ADDR, 32'h3ffffff, 32'h3);
        go(OP_READ, 3'h2, 26'h4, 16'h0, 1'h1);
        go(OP_ENTER, 3'h6, 26'h0, 16'ha506, 1'h0);
        go(OP_READ, 3'h6, 26'h200, 16'h0, 1'h1);
        go(OP_READ, 3'h6, 26'h1ff, 16'h0, 1'h0);
        low <= 1'h1;
        repeat (4) @(posedge clk);
        rc(REG_STATUS, 32'h10, 32'h10);
        go(OP_WRITE, 3'h6, 26'h60000, 16'h6000, 1'h1);
        low <= 1'h0;
        repeat (4) @(posedge clk);
        go(OP_HWRESET, 3'h0, 26'h0, 16'h0, 1'h0);
        go(OP_ENTER, 3'h3, 26'h0, 16'ha503, 1'h0);
        go(OP_READ, 3'h3, 26'h50000, 16'h0, 1'h0);
        rc(REG_DECODED, 32'h1, 32'h1);
        results();
    end
endmodule : testbench
`default_nettype wire
